//--- inc/mra_params.svh
`ifndef MRA_PARAMS_SVH
`define MRA_PARAMS_SVH

// ----------------------------------------
// region decode
// ----------------------------------------
`define MRA_NUM_REGIONS 16
`define MRA_REG_MSB 31
`define MRA_REG_LSB 28
`define MRA_REG_W 4

// ----------------------------------------
// reset attributes: nothing cacheable, all side effect
// ----------------------------------------
`define MRA_CACHE_RST 16'h0000
`define MRA_SIDE_RST 16'hFFFF

// ----------------------------------------
// bus access shaping
// ----------------------------------------
`define MRA_DW_SIZE 2'h3
`define MRA_DW_MASK 32'hFFFF_FFF8
`define MRA_DW_LSB 3
`define MRA_BYTES 8

// ----------------------------------------
// buffers
// ----------------------------------------
`define MRA_FIFO_DEPTH 4
`define MRA_PTR_W 2
`define MRA_CNT_W 3

// ----------------------------------------
// local memories, sizes in KB
// ----------------------------------------
`define MRA_INSTR_LOCAL_MEM_BASE 32'hF000_0000
`define MRA_DATA_LOCAL_MEM_BASE 32'hF008_0000
`define MRA_INSTR_LOCAL_MEM_KB 32'h0000_0040
`define MRA_DATA_LOCAL_MEM_KB 32'h0000_0030
`define MRA_KB_SHIFT 10
`define MRA_MEM_KB_MIN 32'h0000_0004
`define MRA_MEM_KB_MAX 32'h0000_0200
`define MRA_MEM_KB_DATA_ONLY 32'h0000_0030

`endif

//--- inc/mra_pkg.sv
`include "mra_params.svh"

package mra_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic fetch;
    logic cacheable;
  } mra_rd_entry_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] data;
    logic [`MRA_BYTES-1:0] be;
    logic side;
  } mra_wr_entry_s;

  typedef struct packed {
    logic [`MRA_NUM_REGIONS-1:0] cache;
    logic [`MRA_NUM_REGIONS-1:0] side;
    logic stg_valid;
    logic [31:0] stg_addr;
    logic [63:0] stg_data;
    logic [`MRA_BYTES-1:0] stg_be;
    logic spec_refused;
    logic loc_valid;
    logic loc_instr;
  } mra_state_s;

endpackage

//--- inc/mra_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mra_fifo_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

`default_nettype wire

//--- hdl/mra_fifo.sv
`include "mra_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mra_fifo
  import mra_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // queue ports
  mra_fifo_if.fifo q
);

  typedef struct packed {
    logic [`MRA_FIFO_DEPTH-1:0][W-1:0] mem;
    logic [`MRA_PTR_W-1:0] wp;
    logic [`MRA_PTR_W-1:0] rp;
    logic [`MRA_CNT_W-1:0] cnt;
  } mra_fifo_state_s;

  mra_fifo_state_s st_reg;
  mra_fifo_state_s st_next;
  logic push;
  logic pop;

  // strict first-in first-out, no bypass
  assign q.push_ready = st_reg.cnt != `MRA_CNT_W'(`MRA_FIFO_DEPTH);
  assign q.pop_valid = st_reg.cnt != '0;
  assign q.pop_data = st_reg.mem[st_reg.rp];
  assign push = q.push_valid & q.push_ready;
  assign pop = q.pop_valid & q.pop_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = q.push_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + `MRA_CNT_W'(push) - `MRA_CNT_W'(pop);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_fifo_order: assert property (@(posedge core_clk_i) disable iff (rst_i)
    push && !pop && st_reg.cnt == '0 |=> q.pop_data == $past(q.push_data))
    else $error("fifo head is not the oldest entry");

endmodule

`default_nettype wire

//--- hdl/mra_top.sv
`include "mra_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mra_top
  import mra_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // region attribute programming
  input wire logic cfg_cache_we_i,
  input wire logic cfg_side_we_i,
  input wire logic [`MRA_REG_W-1:0] cfg_region_i,
  input wire logic cfg_cache_i,
  input wire logic cfg_side_i,
  output logic [`MRA_NUM_REGIONS-1:0] cfg_cache_o,
  output logic [`MRA_NUM_REGIONS-1:0] cfg_side_o,
  // access request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_fetch_i,
  input wire logic req_spec_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic [63:0] req_wdata_i,
  input wire logic [`MRA_BYTES-1:0] req_be_i,
  // access outcome
  output logic spec_refused_o,
  output logic loc_valid_o,
  output logic loc_instr_o,
  // read buffer to system bus
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [31:0] rd_addr_o,
  output logic [1:0] rd_size_o,
  output logic rd_fetch_o,
  output logic rd_cacheable_o,
  // write buffer to system bus
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [31:0] wr_addr_o,
  output logic [63:0] wr_data_o,
  output logic [`MRA_BYTES-1:0] wr_be_o,
  output logic wr_side_o
);

  // ----------------------------------------
  // state and buffers
  // ----------------------------------------
  mra_state_s st_reg;
  mra_state_s st_next;
  mra_rd_entry_s rd_in;
  mra_rd_entry_s rd_out;
  mra_wr_entry_s wr_in;
  mra_wr_entry_s wr_out;

  mra_fifo_if #(.W($bits(mra_rd_entry_s))) rdq ();
  mra_fifo_if #(.W($bits(mra_wr_entry_s))) wrq ();

  mra_fifo #(.W($bits(mra_rd_entry_s))) u_rd_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .q(rdq)
  );

  mra_fifo #(.W($bits(mra_wr_entry_s))) u_wr_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .q(wrq)
  );

  // ----------------------------------------
  // region lookup
  // ----------------------------------------
  logic [`MRA_REG_W-1:0] region;
  logic r_side;
  logic r_cache;
  logic instr_local_mem_hit;
  logic data_local_mem_hit;
  logic local_hit;
  logic [31:0] instr_local_mem_off;
  logic [31:0] data_local_mem_off;

  assign region = req_addr_i[`MRA_REG_MSB:`MRA_REG_LSB];
  assign r_side = st_reg.side[region];
  // side effect dominates so an illegal pair can never reach a cache
  assign r_cache = st_reg.cache[region] & ~r_side;
  assign instr_local_mem_off = req_addr_i - `MRA_INSTR_LOCAL_MEM_BASE;
  assign data_local_mem_off = req_addr_i - `MRA_DATA_LOCAL_MEM_BASE;
  assign instr_local_mem_hit = instr_local_mem_off < (`MRA_INSTR_LOCAL_MEM_KB << `MRA_KB_SHIFT);
  assign data_local_mem_hit = data_local_mem_off < (`MRA_DATA_LOCAL_MEM_KB << `MRA_KB_SHIFT);
  // fetches only see the instruction memory, data only the data memory
  assign local_hit = req_fetch_i ? instr_local_mem_hit : data_local_mem_hit;

  // ----------------------------------------
  // access steering
  // ----------------------------------------
  logic is_load;
  logic is_store;
  logic spec_drop;
  logic merge_now;
  logic stg_push;
  logic side_push;

  assign is_load = req_valid_i & ~req_write_i & ~local_hit;
  assign is_store = req_valid_i & req_write_i & ~local_hit;
  assign spec_drop = r_side & req_spec_i;
  // back-to-back side-effect-free stores to one double-word keep combining in the staging slot
  assign merge_now = is_store & ~spec_drop & st_reg.stg_valid & ~r_side
    & (req_addr_i[31:`MRA_DW_LSB] == st_reg.stg_addr[31:`MRA_DW_LSB]);
  assign stg_push = st_reg.stg_valid & ~merge_now;
  assign side_push = is_store & ~spec_drop & r_side & ~st_reg.stg_valid;

  always_comb begin
    rd_in.addr = r_side ? req_addr_i : (req_addr_i & `MRA_DW_MASK);
    rd_in.size = r_side ? req_size_i : `MRA_DW_SIZE;
    rd_in.fetch = req_fetch_i;
    rd_in.cacheable = r_cache;
    if (stg_push) begin
      wr_in.addr = st_reg.stg_addr;
      wr_in.data = st_reg.stg_data;
      wr_in.be = st_reg.stg_be;
      wr_in.side = 1'b0;
    end else begin
      wr_in.addr = req_addr_i;
      wr_in.data = req_wdata_i;
      wr_in.be = req_be_i;
      wr_in.side = 1'b1;
    end
  end

  // loads wait for the staging slot so they never pass a store held there; stores already in the write buffer are not waited for
  assign rdq.push_valid = is_load & ~spec_drop & ~st_reg.stg_valid;
  assign rdq.push_data = rd_in;
  assign wrq.push_valid = stg_push | side_push;
  assign wrq.push_data = wr_in;

  always_comb begin
    if (!req_valid_i) begin
      req_ready_o = 1'b0;
    end else if (local_hit || spec_drop) begin
      req_ready_o = 1'b1;
    end else if (!req_write_i) begin
      req_ready_o = rdq.push_valid & rdq.push_ready;
    end else if (merge_now) begin
      req_ready_o = 1'b1;
    end else if (st_reg.stg_valid) begin
      req_ready_o = 1'b0;
    end else if (r_side) begin
      req_ready_o = wrq.push_ready;
    end else begin
      req_ready_o = 1'b1;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (cfg_cache_we_i) begin
      st_next.cache[cfg_region_i] = cfg_cache_i;
    end
    if (cfg_side_we_i) begin
      st_next.side[cfg_region_i] = cfg_side_i;
    end
    st_next.spec_refused = req_valid_i & req_ready_o & spec_drop & ~local_hit;
    st_next.loc_valid = req_valid_i & local_hit;
    st_next.loc_instr = req_fetch_i;
    if (stg_push && wrq.push_ready) begin
      st_next.stg_valid = 1'b0;
    end
    if (merge_now) begin
      for (int b = 0; b < `MRA_BYTES; b++) begin
        if (req_be_i[b]) begin
          st_next.stg_data[b*8 +: 8] = req_wdata_i[b*8 +: 8];
        end
      end
      st_next.stg_be = st_reg.stg_be | req_be_i;
    end else if (is_store && !spec_drop && !r_side && !st_reg.stg_valid) begin
      st_next.stg_valid = 1'b1;
      st_next.stg_addr = req_addr_i;
      st_next.stg_data = req_wdata_i;
      st_next.stg_be = req_be_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.cache <= `MRA_CACHE_RST;
      st_reg.side <= `MRA_SIDE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_out = mra_rd_entry_s'(rdq.pop_data);
  assign wr_out = mra_wr_entry_s'(wrq.pop_data);
  assign rdq.pop_ready = rd_ready_i;
  assign wrq.pop_ready = wr_ready_i;
  assign rd_valid_o = rdq.pop_valid;
  assign rd_addr_o = rd_out.addr;
  assign rd_size_o = rd_out.size;
  assign rd_fetch_o = rd_out.fetch;
  assign rd_cacheable_o = rd_out.cacheable;
  assign wr_valid_o = wrq.pop_valid;
  assign wr_addr_o = wr_out.addr;
  assign wr_data_o = wr_out.data;
  assign wr_be_o = wr_out.be;
  assign wr_side_o = wr_out.side;
  assign cfg_cache_o = st_reg.cache & ~st_reg.side;
  assign cfg_side_o = st_reg.side;
  assign spec_refused_o = st_reg.spec_refused;
  assign loc_valid_o = st_reg.loc_valid;
  assign loc_instr_o = st_reg.loc_instr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_region_pick: assert property (
    rdq.push_valid && rdq.push_ready |-> rd_in.cacheable == (st_reg.cache[region]
      && !st_reg.side[region]))
    else $error("load attribute not taken from its region");
  a_attr_indep: assert property (
    cfg_cache_we_i && !cfg_side_we_i |=> $stable(cfg_side_o))
    else $error("cacheable write disturbed side-effect bits");
  a_cache_gate: assert property (
    rd_valid_o && rd_cacheable_o |-> !cfg_side_o[rd_addr_o[`MRA_REG_MSB:`MRA_REG_LSB]] || $past(cfg_side_we_i))
    else $error("cacheable load from side-effect region");
  a_spec_block: assert property (
    req_valid_i && !local_hit && req_spec_i && r_side |-> !rdq.push_valid && !(wrq.push_valid && wr_in.side)
      ##1 spec_refused_o)
    else $error("speculative access reached a side-effect region");
  a_side_exact: assert property (
    rdq.push_valid && r_side |-> rd_in.size == req_size_i && rd_in.addr == req_addr_i)
    else $error("side-effect load reshaped");
  a_no_side_merge: assert property (
    (merge_now |-> !r_side && st_reg.stg_valid)
      and (wrq.push_valid && wr_in.side |-> r_side && wr_in.be == req_be_i && wr_in.data == req_wdata_i))
    else $error("side-effect store merged");
  a_illegal_pair: assert property (
    (cfg_cache_o & cfg_side_o) == '0)
    else $error("region reported cacheable with side effect");
  a_dword_load: assert property (
    rdq.push_valid && !r_side |-> rd_in.size == `MRA_DW_SIZE && rd_in.addr[`MRA_DW_LSB-1:0] == '0)
    else $error("plain load not a double-word");
  a_mem_size: assert property (
    `MRA_INSTR_LOCAL_MEM_KB >= `MRA_MEM_KB_MIN && `MRA_INSTR_LOCAL_MEM_KB <= `MRA_MEM_KB_MAX
      && (`MRA_INSTR_LOCAL_MEM_KB & (`MRA_INSTR_LOCAL_MEM_KB - 1)) == 0
      && `MRA_DATA_LOCAL_MEM_KB >= `MRA_MEM_KB_MIN && `MRA_DATA_LOCAL_MEM_KB <= `MRA_MEM_KB_MAX
      && ((`MRA_DATA_LOCAL_MEM_KB & (`MRA_DATA_LOCAL_MEM_KB - 1)) == 0
        || `MRA_DATA_LOCAL_MEM_KB == `MRA_MEM_KB_DATA_ONLY))
    else $error("local memory size out of range");
  a_wr_once: assert property (
    wrq.push_valid && wrq.push_ready && wr_in.side |=> !(wrq.push_valid && wrq.push_ready && wr_in.side
      && wr_in.addr == $past(wr_in.addr) && !(req_valid_i && req_ready_o)))
    else $error("side-effect store issued twice");

endmodule

`default_nettype wire

//--- tb/mra_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module mra_bus_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // stall control
  input wire logic stall_i,
  // buffer head acceptance
  output logic rd_ready_o,
  output logic wr_ready_o
);
  // ----------------------------------------
  // random stalls make the buffers hold and queue
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    rd_ready_o <= !rst_i && (!stall_i || $urandom_range(1));
    wr_ready_o <= !rst_i && (!stall_i || $urandom_range(1));
  end
endmodule

`default_nettype wire

//--- tb/testbench.sv
`include "mra_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import mra_pkg::*;
  logic clk = 1'h0, rst = 1'h1, stall = 1'h0;
  logic cwe = 1'h0, swe = 1'h0, cc = 1'h0, cs = 1'h0;
  logic [3:0] creg = 4'h0;
  logic rv = 1'h0, rw = 1'h0, rf = 1'h0, rs = 1'h0;
  logic [31:0] ra = 32'h0;
  logic [1:0] rsz = 2'h0;
  logic [63:0] rd = 64'h0;
  logic [7:0] rbe = 8'h0;
  logic [15:0] co, so;
  logic rdy, sref, lv, li, rdv, rdr, rdf, rdc, wrv, wrr, wrs;
  logic [31:0] rda, wra;
  logic [1:0] rdsz;
  logic [63:0] wrd;
  logic [7:0] wrbe;
  int fail_count = 0;
  int checks_done = 0;
  logic ec [16];
  logic es [16];
  mra_rd_entry_s rq [$];
  mra_wr_entry_s wq [$];
  mra_rd_entry_s er;
  mra_wr_entry_s ew;

  mra_top dut (.core_clk_i(clk), .rst_i(rst), .cfg_cache_we_i(cwe), .cfg_side_we_i(swe),
    .cfg_region_i(creg), .cfg_cache_i(cc), .cfg_side_i(cs), .cfg_cache_o(co), .cfg_side_o(so),
    .req_valid_i(rv), .req_ready_o(rdy), .req_write_i(rw), .req_fetch_i(rf), .req_spec_i(rs),
    .req_addr_i(ra), .req_size_i(rsz), .req_wdata_i(rd), .req_be_i(rbe), .spec_refused_o(sref),
    .loc_valid_o(lv), .loc_instr_o(li), .rd_valid_o(rdv), .rd_ready_i(rdr), .rd_addr_o(rda),
    .rd_size_o(rdsz), .rd_fetch_o(rdf), .rd_cacheable_o(rdc), .wr_valid_o(wrv), .wr_ready_i(wrr),
    .wr_addr_o(wra), .wr_data_o(wrd), .wr_be_o(wrbe), .wr_side_o(wrs));

  mra_bus_model bus (.core_clk_i(clk), .rst_i(rst), .stall_i(stall), .rd_ready_o(rdr), .wr_ready_o(wrr));

  initial begin
    forever #50 clk = ~clk;
  end

  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // side effect always wins over cacheable
  function logic [15:0] exp_cache();
    for (int i = 0; i < 16; i++) exp_cache[i] = ec[i] & ~es[i];
  endfunction

  task cfg(input int r, input logic wc, input logic ws, input logic c, input logic s);
    logic [15:0] sv;
    @(posedge clk);
    cwe <= wc;
    swe <= ws;
    creg <= r[3:0];
    cc <= c;
    cs <= s;
    @(posedge clk);
    cwe <= 1'h0;
    swe <= 1'h0;
    #1;
    if (wc) ec[r] = c;
    if (ws) es[r] = s;
    for (int i = 0; i < 16; i++) sv[i] = es[i];
    chk("cfg_cache", 64'(exp_cache()), 64'(co));
    chk("cfg_side", 64'(sv), 64'(so));
  endtask

  task acc(input logic w, input logic f, input logic s, input logic [31:0] a, input logic [1:0] sz);
    logic [63:0] d;
    logic [7:0] be;
    int r;
    int n;
    d = {$urandom, $urandom};
    be = 8'($urandom_range(255, 1));
    r = a[31:28];
    n = 0;
    @(posedge clk);
    rv <= 1'h1;
    rw <= w;
    rf <= f;
    rs <= s;
    ra <= a;
    rsz <= sz;
    rd <= d;
    rbe <= be;
    do begin
      @(posedge clk);
      n++;
    end while (!rdy && n < 200);
    rv <= 1'h0;
    #1;
    if (n >= 200) chk("req_ready", 1, 0);
    if (r == 15) begin
      chk("loc_valid", 1, lv);
      chk("loc_instr", f, li);
      return;
    end
    chk("spec_refused", s && es[r], sref);
    if (s && es[r]) return;
    if (w) wq.push_back(mra_wr_entry_s'{a, d, be, es[r]});
    else rq.push_back(mra_rd_entry_s'{es[r] ? a : a & `MRA_DW_MASK, es[r] ? sz : 2'h3, f, ec[r] & ~es[r]});
  endtask

  // two plain stores to one double-word with no idle cycle between, so the second one combines
  task merge2(input logic [31:0] a);
    logic [63:0] d1;
    logic [63:0] d2;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [63:0] m;
    int n;
    d1 = {$urandom, $urandom};
    d2 = {$urandom, $urandom};
    b1 = 8'($urandom_range(255, 1));
    b2 = 8'($urandom_range(255, 1));
    for (int i = 0; i < 8; i++) m[i*8 +: 8] = b2[i] ? d2[i*8 +: 8] : d1[i*8 +: 8];
    n = 0;
    @(posedge clk);
    rv <= 1'h1;
    rw <= 1'h1;
    rf <= 1'h0;
    rs <= 1'h0;
    ra <= a;
    rsz <= 2'h3;
    rd <= d1;
    rbe <= b1;
    do begin
      @(posedge clk);
      n++;
    end while (!rdy && n < 200);
    ra <= a ^ 32'h4;
    rd <= d2;
    rbe <= b2;
    @(posedge clk);
    chk("merge_ready", 1, rdy);
    rv <= 1'h0;
    #1;
    if (n >= 200) chk("req_ready", 1, 0);
    wq.push_back(mra_wr_entry_s'{a, m, b1 | b2, 1'h0});
  endtask

  // ----------------------------------------
  // bus side scoreboard, order checked by queue
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst && rdv && rdr) begin
      if (rq.size() == 0) chk("rd_extra", 0, 1);
      else begin
        er = rq.pop_front();
        chk("rd_head", 64'(er), 64'({rda, rdsz, rdf, rdc}));
      end
    end
    if (!rst && wrv && wrr) begin
      if (wq.size() == 0) chk("wr_extra", 0, 1);
      else begin
        ew = wq.pop_front();
        chk("wr_addr", ew.side ? ew.addr : ew.addr & `MRA_DW_MASK, ew.side ? wra : wra & `MRA_DW_MASK);
        chk("wr_data", ew.data, wrd);
        chk("wr_be", 64'(ew.be), 64'(wrbe));
        chk("wr_side", 64'(ew.side), 64'(wrs));
      end
    end
  end

  initial begin
    #(100 * 20000);
    fail_count++;
    summarize();
  end

  initial begin
    int n;
    void'($urandom(32'h62FA));
    for (int i = 0; i < 16; i++) begin
      ec[i] = 1'h0;
      es[i] = 1'h1;
    end
    repeat (2) @(posedge clk);
    #1;
    chk("rst_cache", 64'h0, 64'(co));
    chk("rst_side", 64'hFFFF, 64'(so));
    @(posedge clk);
    rst <= 1'h0;
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      n = $urandom_range(2);
      cfg(i, 1'h1, 1'h1, n == 1, n == 2);
    end
    cfg(15, 1'h1, 1'h1, 1'h0, 1'h0);
    cfg(14, 1'h1, 1'h1, 1'h0, 1'h1);
    cfg(5, 1'h0, 1'h1, 1'h0, 1'h1);
    cfg(5, 1'h1, 1'h0, 1'h1, 1'h0);
    cfg(5, 1'h0, 1'h1, 1'h0, 1'h0);
    $display("test config done");
    acc(1'h0, 1'h1, 1'h0, `MRA_INSTR_LOCAL_MEM_BASE, 2'h3);
    acc(1'h0, 1'h0, 1'h0, `MRA_DATA_LOCAL_MEM_BASE + 32'h4, 2'h2);
    $display("test local done");
    for (int i = 0; i < 80; i++) begin
      if (i == 40) stall <= 1'h1;
      n = $urandom_range(3);
      acc(n == 0, n == 1, n == 3, {4'($urandom_range(14)), 28'($urandom)}, 2'($urandom_range(3)));
    end
    acc(1'h1, 1'h0, 1'h0, 32'hE000_0010, 2'h3);
    acc(1'h1, 1'h0, 1'h0, 32'hE000_0014, 2'h2);
    acc(1'h0, 1'h0, 1'h1, 32'hE000_0020, 2'h1);
    merge2(32'h5000_0100);
    $display("test traffic done");
    n = 0;
    while ((rq.size() + wq.size()) > 0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk("drained", 64'h0, 64'(rq.size() + wq.size()));
    $display("test drain done");
    summarize();
  end
endmodule

`default_nettype wire
